/* pkg/bald_pkg.sv */
// Purpose: Shared constants and types for the bridge abort and legacy display decode block.
// Assumes: AXI4-Lite register access with 32-bit data, one clock.
// Notes: Functional notes follow.
package bald_pkg;

  localparam logic [7:0] BALD_ADDR_CTRL = 8'h00;
  localparam logic [7:0] BALD_ADDR_STAT = 8'h04;
  localparam logic [7:0] BALD_ADDR_MASK = 8'h08;

  localparam int BALD_BIT_VGA_EN = 19;
  localparam int BALD_BIT_FULLDEC = 20;
  localparam int BALD_BIT_MAREP = 21;
  localparam int BALD_BIT_FATAL = 0;
  localparam int BALD_BIT_MEMEN = 1;
  localparam int BALD_BIT_IOEN = 2;
  localparam int BALD_BIT_SERREN = 3;
  localparam logic [31:0] BALD_CTRL_WMASK = 32'h0038_000F;
  localparam logic [31:0] BALD_CTRL_RESET = 32'h0000_0000;

  localparam logic [31:0] BALD_ALL_ONES = 32'hFFFF_FFFF;
  localparam logic [31:0] BALD_MEM_LO = 32'h000A_0000;
  localparam logic [31:0] BALD_MEM_HI = 32'h000B_FFFF;
  localparam logic [9:0] BALD_IO_A_LO = 10'h3B0;
  localparam logic [9:0] BALD_IO_A_HI = 10'h3BB;
  localparam logic [9:0] BALD_IO_B_LO = 10'h3C0;
  localparam logic [9:0] BALD_IO_B_HI = 10'h3DF;

  localparam int BALD_NSTAT = 4;
  localparam int BALD_EV_TABORT = 0;
  localparam int BALD_EV_DROP = 1;
  localparam int BALD_EV_ERRMSG = 2;
  localparam int BALD_EV_BLOCK = 3;

  localparam logic [1:0] BALD_RESP_OKAY = 2'b00;
  localparam logic [1:0] BALD_RESP_SLVERR = 2'b10;

  // One forwarding request seen at the decoder
  typedef struct packed {
    logic valid;
    logic isIo;
    logic [31:0] addr;
    logic inBaseLimit;
  } bald_req_t;

  // Completion or abort returning to the initiator
  typedef struct packed {
    logic valid;
    logic isRead;
    logic isUr;
  } bald_cpl_t;

endpackage : bald_pkg

/* rtl/bald_bridge_ctrl.sv */
// Purpose: Master-abort reporting and legacy display window decode for a PCIe to PCI bridge.
// Assumes: Requests and completions come from logic on the same clock.
// Notes: Decisions are registered, one cycle after the request.
//
// Register access over AXI4-Lite and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
module bald_bridge_ctrl #(
  parameter bit AER_PRESENT = 1'b1
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire bald_pkg::bald_req_t downReq,
  input wire bald_pkg::bald_req_t upReq,
  input wire bald_pkg::bald_cpl_t urCpl,
  input wire logic postedAbort,
  input wire logic pciMode,
  output logic downFwd,
  output logic upFwd,
  output logic cplDataOnes,
  output logic cplNormal,
  output logic cplTargetAbort,
  output logic postedDrop,
  output logic errNonfatal,
  output logic errFatal,
  output logic irq
);

  // ---------------------------------------------------------------
  // Register bus
  // ---------------------------------------------------------------
  logic [31:0] ctrl_r;
  logic [bald_pkg::BALD_NSTAT-1:0] stat_r;
  logic [bald_pkg::BALD_NSTAT-1:0] mask_r;
  logic [7:0] awAddr_r;
  logic [31:0] wData_r;
  logic [3:0] wStrb_r;
  logic awHave_r;
  logic wHave_r;

  wire awTake = s_axi_awvalid && s_axi_awready;
  wire wTake = s_axi_wvalid && s_axi_wready;
  wire doWrite = awHave_r && wHave_r && !s_axi_bvalid;
  wire wrCtrl = doWrite && (awAddr_r == bald_pkg::BALD_ADDR_CTRL);
  wire wrMask = doWrite && (awAddr_r == bald_pkg::BALD_ADDR_MASK);
  // Status writes are accepted but change nothing; only a read clears it
  wire wrHit = wrCtrl || wrMask || (awAddr_r == bald_pkg::BALD_ADDR_STAT);
  wire arTake = s_axi_arvalid && s_axi_arready;
  wire rdSelCtrl = (s_axi_araddr == bald_pkg::BALD_ADDR_CTRL);
  wire rdSelStat = (s_axi_araddr == bald_pkg::BALD_ADDR_STAT);
  wire rdSelMask = (s_axi_araddr == bald_pkg::BALD_ADDR_MASK);
  wire rdStat = arTake && rdSelStat;
  wire rdHit = rdSelCtrl || rdSelStat || rdSelMask;
  // Status and mask occupy the low bits of their words
  wire [31:0] statWord = {{(32 - bald_pkg::BALD_NSTAT){1'b0}}, stat_r};
  wire [31:0] maskWord = {{(32 - bald_pkg::BALD_NSTAT){1'b0}}, mask_r};
  // Unmapped offsets read as zero and answer with an error
  wire [31:0] rdMux = rdSelCtrl ? ctrl_r :
    rdSelStat ? statWord :
    rdSelMask ? maskWord : 32'h0000_0000;

  // Byte strobes widen to a bit mask for the writable fields
  logic [31:0] byteMask;
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      byteMask[i*8 +: 8] = {8{wStrb_r[i]}};
    end
  end
  wire [31:0] wrBits = byteMask & bald_pkg::BALD_CTRL_WMASK;
  wire [31:0] ctrlNxt = (ctrl_r & ~wrBits) | (wData_r & wrBits);
  wire [bald_pkg::BALD_NSTAT-1:0] maskNxt =
    (mask_r & ~byteMask[bald_pkg::BALD_NSTAT-1:0]) |
    (wData_r[bald_pkg::BALD_NSTAT-1:0] & byteMask[bald_pkg::BALD_NSTAT-1:0]);

  // Address and data may arrive in either order; each waits for the other
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      awHave_r <= 1'b0;
      wHave_r <= 1'b0;
      awAddr_r <= 8'h00;
      wData_r <= 32'h0000_0000;
      wStrb_r <= 4'h0;
    end else begin
      if (awTake) begin
        awHave_r <= 1'b1;
        awAddr_r <= s_axi_awaddr;
      end else if (doWrite) begin
        awHave_r <= 1'b0;
      end
      if (wTake) begin
        wHave_r <= 1'b1;
        wData_r <= s_axi_wdata;
        wStrb_r <= s_axi_wstrb;
      end else if (doWrite) begin
        wHave_r <= 1'b0;
      end
    end
  end

  // Readies stay low while a response waits, so one write is in flight
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= bald_pkg::BALD_RESP_OKAY;
    end else begin
      s_axi_awready <= !awHave_r && !awTake && !s_axi_bvalid;
      s_axi_wready <= !wHave_r && !wTake && !s_axi_bvalid;
      if (doWrite) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wrHit ? bald_pkg::BALD_RESP_OKAY : bald_pkg::BALD_RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Read data is captured with the address, so later events cannot tear it
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= bald_pkg::BALD_RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !arTake;
      if (arTake) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rdMux;
        s_axi_rresp <= rdHit ? bald_pkg::BALD_RESP_OKAY : bald_pkg::BALD_RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Control bits reset to zero, software may write them at any time
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ctrl_r <= bald_pkg::BALD_CTRL_RESET;
      mask_r <= '0;
    end else begin
      if (wrCtrl) begin
        ctrl_r <= ctrlNxt;
      end
      if (wrMask) begin
        mask_r <= maskNxt;
      end
    end
  end

  // ---------------------------------------------------------------
  // Legacy display window decode
  // ---------------------------------------------------------------
  wire winEn = ctrl_r[bald_pkg::BALD_BIT_VGA_EN];
  wire fullDec = ctrl_r[bald_pkg::BALD_BIT_FULLDEC];
  wire memEn = ctrl_r[bald_pkg::BALD_BIT_MEMEN];
  wire ioEn = ctrl_r[bald_pkg::BALD_BIT_IOEN];

  // One decoder per direction, both fed the same decode mode
  logic downHit;
  logic upHit;

  bald_win_decode downDec (
    .req(downReq),
    .full16(fullDec),
    .hit(downHit)
  );

  bald_win_decode upDec (
    .req(upReq),
    .full16(fullDec),
    .hit(upHit)
  );

  // Full decode only reaches the match through the enabled window
  wire downWin = winEn && downHit;
  wire upWin = winEn && upHit;
  // Space enables gate the window path and the base/limit path alike
  wire downSpace = downReq.isIo ? ioEn : memEn;
  // Window path ignores base/limit and ISA enable
  wire downGo = downReq.valid && downSpace && (downWin || downReq.inBaseLimit);
  // Upstream traffic to window addresses is not claimed while the window is enabled
  wire upGo = upReq.valid && !upWin && !upReq.inBaseLimit;

  // ---------------------------------------------------------------
  // Abort handling
  // ---------------------------------------------------------------
  // Report mode picks silent completion or an abort and a message
  wire maRep = ctrl_r[bald_pkg::BALD_BIT_MAREP];
  wire serrEn = ctrl_r[bald_pkg::BALD_BIT_SERREN];
  // Severity bit is inert without advanced error reporting
  wire fatalSel = AER_PRESENT && ctrl_r[bald_pkg::BALD_BIT_FATAL];
  wire urPci = urCpl.valid && urCpl.isUr && pciMode;
  wire onesNxt = urPci && !maRep && urCpl.isRead;
  wire normNxt = urPci && !maRep && !urCpl.isRead;
  wire tabNxt = urPci && maRep;
  wire dropNxt = postedAbort && !maRep;
  wire msgNxt = postedAbort && maRep && serrEn;
  wire upBlock = upReq.valid && upWin;
  // Bit order follows the event indices of the status word
  wire [bald_pkg::BALD_NSTAT-1:0] events = {upBlock, msgNxt, dropNxt, tabNxt};

  // Forwarding decisions, one cycle after the request
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      downFwd <= 1'b0;
      upFwd <= 1'b0;
    end else begin
      downFwd <= downGo;
      upFwd <= upGo;
    end
  end

  // Answers to the PCI initiator and the silent drop
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cplDataOnes <= 1'b0;
      cplNormal <= 1'b0;
      cplTargetAbort <= 1'b0;
      postedDrop <= 1'b0;
    end else begin
      cplDataOnes <= onesNxt;
      cplNormal <= normNxt;
      cplTargetAbort <= tabNxt;
      postedDrop <= dropNxt;
    end
  end

  // At most one message per abort, only with report mode and SERR enable set; the severity select decides which
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      errNonfatal <= 1'b0;
      errFatal <= 1'b0;
    end else begin
      errNonfatal <= msgNxt && !fatalSel;
      errFatal <= msgNxt && fatalSel;
    end
  end

  // ---------------------------------------------------------------
  // Interrupt status: read clears, a new event in that cycle wins
  // ---------------------------------------------------------------
  // Set beats clear, so an event landing on the read is not lost
  wire [bald_pkg::BALD_NSTAT-1:0] statKept = rdStat ? '0 : stat_r;
  wire [bald_pkg::BALD_NSTAT-1:0] statNxt = statKept | events;
  wire irqNxt = |(statNxt & mask_r);

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      stat_r <= '0;
    end else begin
      stat_r <= statNxt;
    end
  end

  // Interrupt is built from the next status, so it never lags the flags
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= irqNxt;
    end
  end

endmodule : bald_bridge_ctrl

// ---------------------------------------------------------------
// Display window match for one request
// ---------------------------------------------------------------
// Kept apart so both directions decode the window the same way
module bald_win_decode (
  input wire bald_pkg::bald_req_t req,
  input wire logic full16,
  output logic hit
);
  wire [9:0] lowBits = req.addr[9:0];
  wire [5:0] aliasBits = req.addr[15:10];
  wire [15:0] upperBits = req.addr[31:16];
  wire inRangeA = (lowBits >= bald_pkg::BALD_IO_A_LO) && (lowBits <= bald_pkg::BALD_IO_A_HI);
  wire inRangeB = (lowBits >= bald_pkg::BALD_IO_B_LO) && (lowBits <= bald_pkg::BALD_IO_B_HI);
  // Only the first 64 KB of I/O space can match
  wire ioLow64k = (upperBits == 16'h0000);
  // Low ten bits pick one of the two display ranges
  wire ioLowHit = inRangeA || inRangeB;
  // Ten-bit mode lets every kilobyte of the first 64 KB alias onto the window
  wire aliasOk = !full16 || (aliasBits == 6'h00);
  wire ioHit = ioLow64k && ioLowHit && aliasOk;
  // Frame buffer range, both ends included, no aliases
  wire memAbove = (req.addr >= bald_pkg::BALD_MEM_LO);
  wire memBelow = (req.addr <= bald_pkg::BALD_MEM_HI);
  wire memHit = memAbove && memBelow;

  assign hit = req.isIo ? ioHit : memHit;

endmodule : bald_win_decode

/* tb/bald_bridge_ctrl_monitor.sv */
// Purpose: Port-level checks of the bridge abort and display decode block.
// Assumes: One clock, reset active high.
// Notes: Window enable is rebuilt from register writes seen on the bus.
`timescale 1ns/1ps
module bald_bridge_ctrl_monitor (
  input wire logic clock,
  input wire logic rst,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire bald_pkg::bald_req_t downReq,
  input wire bald_pkg::bald_req_t upReq,
  input wire bald_pkg::bald_cpl_t urCpl,
  input wire logic postedAbort,
  input wire logic pciMode,
  input wire logic downFwd,
  input wire logic upFwd,
  input wire logic cplDataOnes,
  input wire logic cplNormal,
  input wire logic cplTargetAbort,
  input wire logic postedDrop,
  input wire logic errNonfatal,
  input wire logic errFatal
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  // Shadow of the window enable: a write lands the cycle after both halves are in
  logic awSeen, wSeen, ctrlSel, winBit, winStrb, winOn;
  wire shWrite = awSeen && wSeen && !s_axi_bvalid;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      awSeen <= 1'b0;
      wSeen <= 1'b0;
      ctrlSel <= 1'b0;
      winBit <= 1'b0;
      winStrb <= 1'b0;
      winOn <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awSeen <= 1'b1;
        ctrlSel <= (s_axi_awaddr == bald_pkg::BALD_ADDR_CTRL);
      end else if (shWrite) begin
        awSeen <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wSeen <= 1'b1;
        winBit <= s_axi_wdata[bald_pkg::BALD_BIT_VGA_EN];
        winStrb <= s_axi_wstrb[bald_pkg::BALD_BIT_VGA_EN / 8];
      end else if (shWrite) begin
        wSeen <= 1'b0;
      end
      if (shWrite && ctrlSel && winStrb) begin
        winOn <= winBit;
      end
    end
  end
  wire [9:0] upLowA = upReq.addr[9:0];
  wire upLowHit = (upLowA >= 10'h3B0 && upLowA <= 10'h3BB) || (upLowA >= 10'h3C0 &&
    upLowA <= 10'h3DF);
  wire upIoIn = upReq.addr[31:16] == 16'h0000 && upReq.addr[15:10] == 6'h00 && upLowHit;
  wire [9:0] lowA = downReq.addr[9:0];
  wire lowHit = (lowA >= 10'h3B0 && lowA <= 10'h3BB) || (lowA >= 10'h3C0 && lowA <= 10'h3DF);
  wire memIn = downReq.addr >= 32'h000A_0000 && downReq.addr <= 32'h000B_FFFF;
  wire upMemIn = upReq.addr >= 32'h000A_0000 && upReq.addr <= 32'h000B_FFFF;
  wire plain = downReq.valid && !downReq.inBaseLimit;
  sequence sPostErr;
    postedAbort ##1 (errNonfatal || errFatal);
  endsequence
  AST_DOWN_CAUSE: assert property (downFwd |-> $past(downReq.valid))
    else $error("forward without request");
  AST_IO_HIGH: assert property (plain && downReq.isIo && downReq.addr[31:16] != 16'h0000
    |=> !downFwd) else $error("io above 64K forwarded");
  AST_IO_LOW: assert property (plain && downReq.isIo && !lowHit |=> !downFwd)
    else $error("io outside ranges forwarded");
  AST_MEM_OUT: assert property (plain && !downReq.isIo && !memIn |=> !downFwd)
    else $error("memory outside window forwarded");
  AST_UP_BLOCK: assert property (winOn && upReq.valid && !upReq.isIo && upMemIn |=> !upFwd)
    else $error("window hit claimed upstream");
  AST_UP_IO_BLOCK: assert property (winOn && upReq.valid && upReq.isIo && upIoIn |=> !upFwd)
    else $error("window io claimed upstream");
  AST_ONES: assert property (cplDataOnes |-> $past(urCpl.valid && urCpl.isUr && urCpl.isRead
    && pciMode)) else $error("all ones without read UR");
  AST_TABORT: assert property (cplTargetAbort |-> $past(urCpl.valid && urCpl.isUr && pciMode)
    && !cplDataOnes && !cplNormal) else $error("bad target abort");
  AST_DROP: assert property (postedDrop |-> $past(postedAbort) && !errNonfatal && !errFatal)
    else $error("bad posted drop");
  AST_ONE_SEV: assert property (sPostErr |-> !(errNonfatal && errFatal))
    else $error("both severities sent");
endmodule : bald_bridge_ctrl_monitor
bind bald_bridge_ctrl bald_bridge_ctrl_monitor mon (.clock, .rst, .s_axi_awaddr, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
  .downReq, .upReq, .urCpl, .postedAbort, .pciMode, .downFwd, .upFwd, .cplDataOnes, .cplNormal,
  .cplTargetAbort, .postedDrop, .errNonfatal, .errFatal);

/* tb/bald_far_model.sv */
// Purpose: PCIe upstream port and PCI agents facing the block.
// Assumes: Each request or pulse lasts one cycle.
// Notes: Released address lines flip so stale values are never reused.
`timescale 1ns/1ps
module bald_far_model (
  input wire logic clock,
  output bald_pkg::bald_req_t downReq,
  output bald_pkg::bald_req_t upReq,
  output bald_pkg::bald_cpl_t urCpl,
  output logic postedAbort,
  output logic pciMode
);
  initial begin
    downReq = '0;
    upReq = '0;
    urCpl = '0;
    postedAbort = 1'b0;
    pciMode = 1'b1;
  end
  task automatic req(input bit up, input bit io, input logic [31:0] a, input bit bl);
    @(posedge clock);
    if (up) upReq <= {1'b1, io, a, bl};
    else downReq <= {1'b1, io, a, bl};
    @(posedge clock);
    upReq <= {1'b0, upReq.isIo, ~upReq.addr, upReq.inBaseLimit};
    downReq <= {1'b0, downReq.isIo, ~downReq.addr, downReq.inBaseLimit};
  endtask : req
  task automatic cpl(input bit rd);
    @(posedge clock);
    urCpl <= {1'b1, rd, 1'b1};
    @(posedge clock);
    urCpl <= '0;
  endtask : cpl
  task automatic abort();
    @(posedge clock);
    postedAbort <= 1'b1;
    @(posedge clock);
    postedAbort <= 1'b0;
  endtask : abort
  task automatic mode(input bit p);
    @(posedge clock);
    pciMode <= p;
  endtask : mode
endmodule : bald_far_model

/* tb/bridge_abort_and_legacy_decode_tb.sv */
// Purpose: Self-checking bench for abort reporting and display decode.
// Assumes: CTRL 0x00, STAT 0x04, MASK 0x08; outputs one cycle after request.
// Notes: Far side comes from bald_far_model.
`timescale 1ns/1ps
module bridge_abort_and_legacy_decode_tb;
  logic clock, rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  bald_pkg::bald_req_t downReq, upReq;
  bald_pkg::bald_cpl_t urCpl;
  logic postedAbort, pciMode, downFwd, upFwd, cplDataOnes, cplNormal, cplTargetAbort;
  logic postedDrop, errNonfatal, errFatal, irq;
  int num_errors = 0, cmp_count = 0, cyc = 0;
  bald_bridge_ctrl DUT (.clock, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .downReq, .upReq, .urCpl, .postedAbort, .pciMode, .downFwd,
    .upFwd, .cplDataOnes, .cplNormal, .cplTargetAbort, .postedDrop, .errNonfatal, .errFatal,
    .irq);
  bald_far_model m (.clock, .downReq, .upReq, .urCpl, .postedAbort, .pciMode);
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic report_and_stop();
    $display("errors=%0d checks=%0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : report_and_stop
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      num_errors++;
      report_and_stop();
    end
  end
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {a, d, 3'b111};
    fork
      begin do @(posedge clock); while (!s_axi_awready); s_axi_awvalid <= 1'b0; end
      begin do @(posedge clock); while (!s_axi_wready); s_axi_wvalid <= 1'b0; end
    join
    do @(posedge clock); while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk({30'h0, s_axi_bresp}, 32'h0000_0000);
  endtask : axw
  task automatic axr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    @(posedge clock);
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'b11};
    do @(posedge clock); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge clock); while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    chk(s_axi_rdata, d);
    chk({30'h0, s_axi_rresp}, {30'h0, r});
  endtask : axr
  // Forward decision for one request, up selects the PCI side initiator
  task automatic fw(input bit up, input bit io, input logic [31:0] a, input bit bl, input bit e);
    m.req(up, io, a, bl);
    #1 chk({31'h0, up ? upFwd : downFwd}, {31'h0, e});
  endtask : fw
  task automatic ev(input int k, input logic [5:0] e);
    if (k == 2) m.abort();
    else m.cpl(k == 0);
    #1 chk({26'h0, cplDataOnes, cplNormal, cplTargetAbort, postedDrop, errNonfatal, errFatal},
      {26'h0, e});
  endtask : ev
  initial begin
    {rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'b100000;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = {48'h0, 4'hF};
    repeat (20) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    axr(8'h00, 32'h0000_0000, 2'b00);
    axr(8'h0C, 32'h0000_0000, 2'b10);
    axw(8'h00, 32'h0000_0008);
    ev(0, 6'b100000);
    ev(1, 6'b010000);
    ev(2, 6'b000100);
    m.mode(0);
    ev(0, 6'b000000);
    m.mode(1);
    axw(8'h08, 32'h0000_000F);
    #1 chk({31'h0, irq}, 32'h0000_0001);
    axr(8'h04, 32'h0000_0002, 2'b00);
    #1 chk({31'h0, irq}, 32'h0000_0000);
    axw(8'h00, 32'h0020_0008);
    ev(0, 6'b001000);
    m.mode(0);
    ev(0, 6'b000000);
    m.mode(1);
    ev(2, 6'b000010);
    axw(8'h00, 32'h0020_0009);
    ev(2, 6'b000001);
    axw(8'h00, 32'h0020_0000);
    ev(2, 6'b000000);
    axr(8'h04, 32'h0000_0005, 2'b00);
    axw(8'h00, 32'h0008_0006);
    fw(0, 0, 32'h000A_0000, 0, 1);
    fw(0, 0, 32'h000B_FFFF, 0, 1);
    fw(0, 0, 32'h0009_FFFF, 0, 0);
    fw(0, 0, 32'h000C_0000, 0, 0);
    fw(0, 1, 32'h0000_03BB, 0, 1);
    fw(0, 1, 32'h0000_03BC, 0, 0);
    fw(0, 1, 32'h0000_03DF, 0, 1);
    fw(0, 1, 32'h0000_03E0, 0, 0);
    fw(0, 1, 32'h0000_FBB0, 0, 1);
    fw(0, 1, 32'h0001_03B0, 0, 0);
    fw(1, 0, 32'h000A_0000, 0, 0);
    fw(1, 0, 32'h000C_0000, 0, 1);
    fw(1, 1, 32'h0000_03B0, 0, 0);
    axr(8'h04, 32'h0000_0008, 2'b00);
    axw(8'h00, 32'h0018_0004);
    fw(0, 1, 32'h0000_07B0, 0, 0);
    fw(0, 1, 32'h0000_03C0, 0, 1);
    fw(0, 0, 32'h000A_0000, 0, 0);
    axw(8'h00, 32'h0010_0006);
    fw(0, 0, 32'h000A_0000, 0, 0);
    fw(0, 0, 32'h000A_0000, 1, 1);
    fw(0, 1, 32'h0000_07B0, 1, 1);
    report_and_stop();
  end
endmodule : bridge_abort_and_legacy_decode_tb
